// ---- tb/bpg_loop_model.sv ----
// far side: loops the sent stream back on its own slower clock
`timescale 1ns/100ps
module bpg_loop_model (
  input wire logic data_i,
  input wire logic flip_i,
  output logic rx_clk_o,
  output logic rx_data_o
);
  // 400 ns link clock, phase unrelated to the system clock
  initial begin
    rx_clk_o = 1'b0;
    rx_data_o = 1'b0;
    #13;
    forever #200 rx_clk_o = ~rx_clk_o;
  end
  // launch on falling edge so the bit is settled at the rising one
  always @(negedge rx_clk_o) begin
    rx_data_o <= data_i ^ flip_i;
  end
endmodule : bpg_loop_model

// ---- tb/bpg_props.sv ----
// checker on bus timing, transmit pins and lock holding
`timescale 1ns/100ps
module bpg_props #(
  parameter int BLOCK_BITS = 1024,
  parameter int GATE_CYCLES = 100
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire bpg_pkg::bpg_ahb_in_s ahb_i,
  input wire bpg_pkg::bpg_ahb_out_s ahb_o,
  input wire bpg_pkg::bpg_tx_s tx_o,
  input wire logic rx_clk_i,
  input wire logic rx_data_i,
  input wire logic rx_locked_o
);
  import bpg_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // a taken request, then exactly one wait cycle
  sequence s_take;
    ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
  endsequence
  sequence s_answer;
    !ahb_o.hreadyout ##1 ahb_o.hreadyout;
  endsequence
  property p_answer; s_take |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_wait;
    !ahb_o.hreadyout |-> $past(ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready);
  endproperty
  a_wait: assert property (p_wait) else $error("wait without request");
  property p_okay; ahb_o.hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  // read data only moves at a read answer
  property p_rdata;
    $changed(ahb_o.hrdata) |-> ahb_o.hreadyout && !$past(ahb_o.hreadyout)
      && !$past(ahb_i.hwrite, 2);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_inv; !$past(sys_rst_i) |-> tx_o.data_n != tx_o.data; endproperty
  a_inv: assert property (p_inv) else $error("inverted output wrong");
  property p_sync; tx_o.sync |=> !tx_o.sync; endproperty
  a_sync: assert property (p_sync) else $error("sync wider than a bit");
  // half-rate rails hold each pair for two bit times
  property p_rails;
    $changed({tx_o.rail_a, tx_o.rail_b}) |=> $stable({tx_o.rail_a, tx_o.rail_b});
  endproperty
  a_rails: assert property (p_rails) else $error("rail not half rate");
  property p_lock; $rose(rx_locked_o) |=> rx_locked_o [*8]; endproperty
  a_lock: assert property (p_lock) else $error("lock dropped early");
endmodule : bpg_props

bind bpg_top bpg_props #(.BLOCK_BITS(BLOCK_BITS), .GATE_CYCLES(GATE_CYCLES)) u_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ahb_i(ahb_i), .ahb_o(ahb_o), .tx_o(tx_o),
  .rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i), .rx_locked_o(rx_locked_o));

// ---- tb/tb.sv ----
// self-checking bench: registers, transmit stream, loop-back lock, counters
`timescale 1ns/100ps
module tb;
  import bpg_pkg::*;
  localparam logic [15:0] WD = 16'hC3A5;
  logic clk_i;
  logic sys_rst_i;
  logic flip;
  logic rx_clk;
  logic rx_data;
  logic lk;
  logic [31:0] q;
  bpg_ahb_in_s ahb;
  bpg_ahb_in_s ahb_in;
  bpg_ahb_out_s ahb_o;
  bpg_tx_s tx;
  int n_errors;
  int n_compared;
  // one slave: its ready is the bus ready
  always_comb begin
    ahb_in = ahb;
    ahb_in.hready = ahb_o.hreadyout;
  end
  bpg_top #(.BLOCK_BITS(64), .GATE_CYCLES(100)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ahb_i(ahb_in), .ahb_o(ahb_o), .tx_o(tx), .rx_clk_i(rx_clk), .rx_data_i(rx_data),
    .rx_locked_o(lk));
  bpg_loop_model u_far (.data_i(tx.data), .flip_i(flip), .rx_clk_o(rx_clk),
    .rx_data_o(rx_data));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // bounded wait for ready at a rising edge
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ahb_o.hreadyout !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_errors++;
      conclude();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    ahb.hsel <= 1'b1;
    ahb.haddr <= {24'h000000, a};
    ahb.htrans <= 2'h2;
    ahb.hwrite <= w;
    rdy();
    ahb.hsel <= 1'b0;
    ahb.htrans <= 2'h0;
    ahb.hwdata <= d;
    rdy();
    q = ahb_o.hrdata;
  endtask : bus
  task automatic t_regs;
    bus(0, REG_CTRL, 0);
    chk(q, 0);
    bus(0, REG_WORD, 0);
    chk(q, 32'h0000AAAA);
    bus(0, 8'h20, 0);
    chk(q, 0);
  endtask : t_regs
  // every length must relock within a few blocks
  task automatic t_prbs;
    for (int i = 0; i < 5; i++) begin
      bus(1, REG_CTRL, {28'h0000000, 3'(i), 1'b0});
      cyc(2600);
      chk({31'h0, lk}, 1);
    end
  endtask : t_prbs
  task automatic t_period;
    int n;
    bus(1, REG_CTRL, 0);
    n = 0;
    while (tx.sync !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    // no frame start at all: give up rather than judge a stale count
    if (n >= 300) begin
      n_errors++;
      conclude();
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tx.sync !== 1'b1 && n < 300);
    chk(n, 127);
  endtask : t_period
  // two flipped bits while locked give two errors
  task automatic t_count;
    cyc(2600);
    bus(1, REG_CTRL, 32'h200);
    cyc(2000);
    bus(1, REG_CTRL, 32'h100);
    bus(0, REG_ERRS, 0);
    chk(q, 0);
    bus(0, REG_BITS, 0);
    chk({31'h0, q > 200 && q < 300}, 1);
    bus(1, REG_CTRL, 32'h200);
    flip <= 1'b1;
    cyc(16);
    flip <= 1'b0;
    cyc(600);
    bus(1, REG_CTRL, 32'h100);
    bus(0, REG_ERRS, 0);
    chk(q, 2);
    bus(0, REG_FREQ, 0);
    chk({31'h0, q == 12 || q == 13}, 1);
  endtask : t_count
  // inverted stream never locks, so nothing is counted
  task automatic t_search;
    flip <= 1'b1;
    cyc(2600);
    chk({31'h0, lk}, 0);
    bus(1, REG_CTRL, 32'h200);
    cyc(1000);
    bus(1, REG_CTRL, 32'h100);
    bus(0, REG_ERRS, 0);
    chk(q, 0);
    bus(0, REG_BITS, 0);
    chk(q, 0);
    flip <= 1'b0;
  endtask : t_search
  // word mode, injection every 1000 bits
  task automatic t_word;
    int n;
    int bad;
    int sy;
    int rl;
    bus(1, REG_WORD, {16'h0000, WD});
    bus(1, REG_CTRL, 32'h71);
    n = 0;
    while (tx.sync !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) begin
      n_errors++;
      conclude();
    end
    bad = 0;
    sy = 0;
    rl = 0;
    // rails carry each even/odd pair and are never touched by insertion
    for (int i = 0; i < 3000; i++) begin
      if (tx.data !== WD[i % 16]) bad++;
      if (tx.sync !== (i % 16 == 0)) sy++;
      if (i % 2 == 0 && {tx.rail_a, tx.rail_b} !== {WD[i % 16], WD[i % 16 + 1]}) rl++;
      @(posedge clk_i);
    end
    chk(bad, 3);
    chk(sy, 0);
    chk(rl, 0);
  endtask : t_word
  initial begin
    sys_rst_i = 1'b1;
    flip = 1'b0;
    ahb = '0;
    ahb.hsize = 3'h2;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_prbs();
    t_period();
    t_count();
    t_search();
    t_word();
    conclude();
  end
endmodule : tb

// ---- verilog/bpg_pkg.sv ----
// shared constants and carriers for the bit error rate pattern generator and checker
package bpg_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WORD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_ERRS = 8'h0C;
  localparam logic [7:0] REG_BITS = 8'h10;
  localparam logic [7:0] REG_FREQ = 8'h14;
  // control field positions
  localparam int CTL_WORD = 0;
  localparam int CTL_SEL_LO = 1;
  localparam int CTL_INJ = 4;
  localparam int CTL_EXP_LO = 5;
  localparam int CTL_LATCH = 8;
  localparam int CTL_CLEAR = 9;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [15:0] WORD_RST = 16'hAAAA;
  // pattern select codes
  localparam logic [2:0] SEL_P7 = 3'h0;
  localparam logic [2:0] SEL_P15 = 3'h1;
  localparam logic [2:0] SEL_P17 = 3'h2;
  localparam logic [2:0] SEL_P20 = 3'h3;
  localparam logic [2:0] SEL_P23 = 3'h4;
  // error insertion decade range
  localparam logic [2:0] EXP_MIN = 3'h3;
  localparam logic [2:0] EXP_MAX = 3'h7;
  localparam int DECADE = 10;
  // sync thresholds in parts per thousand
  localparam int THR_PRBS_PPT = 250;
  localparam int THR_WORD_PPT = 31;
  localparam int PPT = 1000;
  // timing
  localparam int CLK_MHZ = 20;
  localparam int FREQ_GATE_NS = 1000000;
  localparam int FREQ_GATE_CYC = FREQ_GATE_NS * CLK_MHZ / 1000;
  localparam int LFSR_W = 23;
  localparam int WORD_W = 16;

  typedef enum logic {SRCH, LOCK} bpg_sync_e;

  // ahb-lite slave side inputs grouped
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } bpg_ahb_in_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } bpg_ahb_out_s;

  // transmit pins
  typedef struct packed {
    logic data;
    logic data_n;
    logic rail_a;
    logic rail_b;
    logic sync;
  } bpg_tx_s;
endpackage : bpg_pkg

// ---- verilog/bpg_top.sv ----
// pattern generator, receive checker and counters with an ahb-lite register port
`timescale 1ns/100ps
module bpg_top #(
  parameter int BLOCK_BITS = 1024,
  parameter int GATE_CYCLES = bpg_pkg::FREQ_GATE_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire bpg_pkg::bpg_ahb_in_s ahb_i,
  output bpg_pkg::bpg_ahb_out_s ahb_o,
  output bpg_pkg::bpg_tx_s tx_o,
  input wire logic rx_clk_i,
  input wire logic rx_data_i,
  output logic rx_locked_o
);
  import bpg_pkg::*;

  localparam int BLK_W = $clog2(BLOCK_BITS + 1);
  localparam int GATE_W = $clog2(GATE_CYCLES + 1);
  localparam logic [BLK_W-1:0] THR_PRBS = BLK_W'(BLOCK_BITS * THR_PRBS_PPT / PPT);
  localparam logic [BLK_W-1:0] THR_WORD = BLK_W'(BLOCK_BITS * THR_WORD_PPT / PPT);

  // refuse sizes the threshold arithmetic cannot serve
  if (BLOCK_BITS < 64 || GATE_CYCLES < 2) begin : g_bad
    $error("bpg_top: BLOCK_BITS or GATE_CYCLES too small");
  end

  typedef struct packed {
    // bus
    logic pend;
    logic pend_wr;
    logic [7:0] pend_addr;
    logic [31:0] rdata;
    logic readyout;
    logic [9:0] ctrl;
    logic [15:0] word;
    // transmit
    logic phase;
    logic [LFSR_W-1:0] lfsr;
    logic [3:0] widx;
    logic [23:0] inj_cnt;
    logic pend_b;
    logic sync_b;
    bpg_tx_s tx;
    // receive link synchronisers
    logic rc1;
    logic rc2;
    logic rc3;
    logic rd1;
    logic rd2;
    // receive checker
    bpg_sync_e st;
    logic [LFSR_W-1:0] rloc;
    logic [3:0] ridx;
    logic [BLK_W-1:0] blk_bits;
    logic [BLK_W-1:0] blk_errs;
    logic [31:0] err_run;
    logic [31:0] bit_run;
    logic [31:0] err_lat;
    logic [31:0] bit_lat;
    logic [GATE_W-1:0] gate;
    logic [31:0] edge_acc;
    logic [31:0] freq;
  } bpg_state_s;

  bpg_state_s q;
  bpg_state_s next_q;

  // prbs length for each select code
  function automatic int plen(input logic [2:0] sel);
    unique case (sel)
      SEL_P15: plen = 15;
      SEL_P17: plen = 17;
      SEL_P20: plen = 20;
      SEL_P23: plen = 23;
      default: plen = 7;
    endcase
  endfunction : plen

  // feedback tap paired with the top stage
  function automatic int ptap(input logic [2:0] sel);
    unique case (sel)
      SEL_P15: ptap = 14;
      SEL_P17: ptap = 14;
      SEL_P20: ptap = 3;
      SEL_P23: ptap = 18;
      default: ptap = 6;
    endcase
  endfunction : ptap

  // next feedback bit of an n-length register
  function automatic logic pfb(input logic [LFSR_W-1:0] s, input logic [2:0] sel);
    pfb = s[plen(sel) - 1] ^ s[ptap(sel) - 1];
  endfunction : pfb

  // one shift with feedback, unused upper stages kept clear
  function automatic logic [LFSR_W-1:0] pstep(input logic [LFSR_W-1:0] s,
                                              input logic [2:0] sel);
    logic [LFSR_W-1:0] m;
    m = LFSR_W'((24'h000001 << plen(sel)) - 24'h000001);
    pstep = {s[LFSR_W-2:0], pfb(s, sel)} & m;
  endfunction : pstep

  // frame start: all n stages high
  function automatic logic pstart(input logic [LFSR_W-1:0] s, input logic [2:0] sel);
    logic [LFSR_W-1:0] m;
    m = LFSR_W'((24'h000001 << plen(sel)) - 24'h000001);
    pstart = (s & m) == m;
  endfunction : pstart

  // insertion interval, one chained decade per exponent step
  function automatic logic [23:0] dec_lim(input logic [2:0] e);
    logic [23:0] l;
    l = 24'h000001;
    for (int i = 0; i < int'(EXP_MAX); i++) begin
      if (i < int'(e)) begin
        l = 24'(l * DECADE);
      end
    end
    dec_lim = l;
  endfunction : dec_lim

  // all next-state logic
  always_comb begin
    logic [LFSR_W-1:0] s1;
    logic [LFSR_W-1:0] s2;
    logic wmode;
    logic [2:0] sel;
    logic [2:0] iexp;
    logic bit_out;
    logic sync_out;
    logic inj;
    logic take;
    logic rbit;
    logic expb;
    logic mis;
    logic rise;
    logic [BLK_W-1:0] thr;
    logic [BLK_W-1:0] errs;
    s1 = '0;
    s2 = '0;
    bit_out = 1'b0;
    sync_out = 1'b0;
    inj = 1'b0;
    expb = 1'b0;
    mis = 1'b0;
    errs = '0;
    next_q = q;
    wmode = q.ctrl[CTL_WORD];
    sel = q.ctrl[CTL_SEL_LO +: 3];
    iexp = q.ctrl[CTL_EXP_LO +: 3];
    if (iexp < EXP_MIN) iexp = EXP_MIN;
    if (iexp > EXP_MAX) iexp = EXP_MAX;
    thr = wmode ? THR_WORD : THR_PRBS;

    // ahb-lite slave: address phase captured, one wait state, then answer
    take = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    next_q.readyout = 1'b1;
    next_q.ctrl[CTL_LATCH] = 1'b0;
    next_q.ctrl[CTL_CLEAR] = 1'b0;
    next_q.pend = 1'b0;
    if (take) begin
      next_q.pend = 1'b1;
      next_q.pend_wr = ahb_i.hwrite;
      next_q.pend_addr = ahb_i.haddr[7:0];
      next_q.readyout = 1'b0;
    end
    if (q.pend && q.pend_wr) begin
      unique case (q.pend_addr)
        REG_CTRL: next_q.ctrl = ahb_i.hwdata[9:0];
        REG_WORD: next_q.word = ahb_i.hwdata[15:0];
        default: ;
      endcase
    end else if (q.pend) begin
      unique case (q.pend_addr)
        REG_CTRL: next_q.rdata = {22'h000000, q.ctrl};
        REG_WORD: next_q.rdata = {16'h0000, q.word};
        REG_STAT: next_q.rdata = {31'h00000000, q.st == LOCK};
        REG_ERRS: next_q.rdata = q.err_lat;
        REG_BITS: next_q.rdata = q.bit_lat;
        REG_FREQ: next_q.rdata = q.freq;
        default: next_q.rdata = 32'h00000000;
      endcase
    end

    // transmit: two shifts per half-rate step, rails muxed into the serial bit
    next_q.phase = ~q.phase;
    if (!q.phase) begin
      if (wmode) begin
        bit_out = q.word[q.widx];
        sync_out = q.widx == 4'h0;
        next_q.pend_b = q.word[q.widx + 4'h1];
        next_q.sync_b = 1'b0;
        next_q.widx = q.widx + 4'h2;
      end else begin
        s1 = pstep(q.lfsr, sel);
        s2 = pstep(s1, sel);
        if (s2 == '0) s2 = pstep({{(LFSR_W-1){1'b0}}, 1'b1}, sel);
        bit_out = s1[0];
        sync_out = pstart(s1, sel);
        next_q.pend_b = s2[0];
        next_q.sync_b = pstart(s2, sel);
        next_q.lfsr = s2;
      end
      next_q.tx.rail_a = bit_out;
      next_q.tx.rail_b = next_q.pend_b;
    end else begin
      bit_out = q.pend_b;
      sync_out = wmode ? 1'b0 : q.sync_b;
    end

    // decade interval counter; only the outgoing bit copy is flipped
    if (q.ctrl[CTL_INJ]) begin
      if (q.inj_cnt >= dec_lim(iexp) - 24'h000001) begin
        next_q.inj_cnt = 24'h000000;
        inj = 1'b1;
      end else begin
        next_q.inj_cnt = q.inj_cnt + 24'h000001;
      end
    end else begin
      next_q.inj_cnt = 24'h000000;
    end
    next_q.tx.data = bit_out ^ inj;
    next_q.tx.data_n = ~(bit_out ^ inj);
    next_q.tx.sync = sync_out;

    // receive link: clock and data through two flops before use
    next_q.rc1 = rx_clk_i;
    next_q.rc2 = q.rc1;
    next_q.rc3 = q.rc2;
    next_q.rd1 = rx_data_i;
    next_q.rd2 = q.rd1;
    rise = q.rc2 && !q.rc3;
    rbit = q.rd2;

    // local reference and bitwise compare on each received bit
    if (rise) begin
      if (wmode) begin
        expb = q.word[q.ridx];
        next_q.ridx = q.ridx + 4'h1;
      end else begin
        expb = pfb(q.rloc, sel);
        next_q.rloc = pstep(q.rloc, sel);
        next_q.rloc[0] = (q.st == SRCH) ? rbit : expb;
      end
      mis = rbit ^ expb;
      errs = q.blk_errs + BLK_W'(mis);
      next_q.blk_errs = errs;
      next_q.blk_bits = q.blk_bits + 1'b1;
      if (q.st == LOCK) begin
        next_q.bit_run = q.bit_run + 32'h00000001;
        next_q.err_run = q.err_run + 32'(mis);
      end
      if (q.blk_bits == BLK_W'(BLOCK_BITS - 1)) begin
        next_q.blk_bits = '0;
        next_q.blk_errs = '0;
        if (errs > thr) begin
          next_q.st = SRCH;
          if (wmode) next_q.ridx = q.ridx + 4'h2;
        end else begin
          next_q.st = LOCK;
        end
      end
    end
    if (q.ctrl[CTL_CLEAR]) begin
      next_q.err_run = 32'h00000000;
      next_q.bit_run = 32'h00000000;
    end
    if (q.ctrl[CTL_LATCH]) begin
      next_q.err_lat = q.err_run;
      next_q.bit_lat = q.bit_run;
    end

    // frequency: received clock edges over a fixed gate of system cycles
    if (q.gate == GATE_W'(GATE_CYCLES - 1)) begin
      next_q.gate = '0;
      next_q.freq = q.edge_acc + 32'(rise);
      next_q.edge_acc = 32'h00000000;
    end else begin
      next_q.gate = q.gate + 1'b1;
      next_q.edge_acc = q.edge_acc + 32'(rise);
    end
  end

  // single state register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.readyout <= 1'b1;
      q.ctrl <= CTRL_RST;
      q.word <= WORD_RST;
      q.lfsr <= {LFSR_W{1'b1}};
      q.st <= SRCH;
    end else begin
      q <= next_q;
    end
  end

  // every output straight from the state flops, except hresp, which is tied low
  assign ahb_o.hrdata = q.rdata;
  assign ahb_o.hreadyout = q.readyout;
  assign ahb_o.hresp = 1'b0;
  assign tx_o = q.tx;
  assign rx_locked_o = q.st == LOCK;
endmodule : bpg_top
